// *** hdl/lspm_pkg.sv ***
package lspm_pkg;

    // Register indexes; the byte address on the bus is four times the index
    localparam logic [9:0] LINK_STATUS_SECOND_IDX = 10'h072;
    localparam logic [9:0] SLOT_CAPABILITIES_SECOND_IDX = 10'h074;
    localparam logic [9:0] SLOT_CONTROL_SECOND_IDX = 10'h078;
    localparam logic [9:0] SLOT_STATUS_SECOND_IDX = 10'h07A;
    localparam logic [9:0] POWER_MGMT_CAPABILITIES_IDX = 10'h0C0;
    localparam logic [9:0] LOAD_CONTROL_IDX = 10'h0F0;
    localparam logic [9:0] LINK_MONITOR_IDX = 10'h0F1;

    localparam int ADR_W = 12;

    // Power management capability header fields
    localparam int CAP_IDENT_LSB = 0;
    localparam int NEXT_PTR_LSB = 8;
    localparam int PM_REV_LSB = 16;
    localparam int INIT_FLAG_BIT = 21;
    localparam int AUX_CURRENT_LSB = 22;
    localparam int LPS1_BIT = 25;
    localparam int LPS2_BIT = 26;
    localparam int PMES_LSB = 27;

    localparam logic [7:0] CAPABILITY_IDENTIFIER = 8'h01;
    localparam logic [2:0] PM_SPEC_REVISION_VALUE = 3'h3;
    localparam logic [2:0] AUX_CURRENT_VALUE = 3'h0;

    localparam logic [7:0] NEXT_PTR_RST = 8'h00;
    localparam logic INIT_FLAG_RST = 1'b0;
    localparam logic [4:0] PME_SUPPORT_RST = 5'h19;

    // Mask position of each power state within the PME support field
    localparam int PME_D0_POS = 0;
    localparam int PME_D3COLD_POS = 4;

    // Power state encoding on the pm_state input
    localparam logic [1:0] PSTATE_D3HOT = 2'h3;

    // Bit positions in the block's own control and monitor registers
    localparam int LOAD_EN_BIT = 0;
    localparam int MON_RATE_BIT = 0;
    localparam int MON_DEEMPH_BIT = 1;
    localparam int MON_COLD_BIT = 2;

    localparam logic [31:0] DATA_RST = 32'h0000_0000;

endpackage

// *** hdl/lspm_sync.sv ***
`timescale 1ns/1ps

module lspm_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } lspm_sync_s;

    lspm_sync_s state_reg;
    lspm_sync_s state_next;

    // One two-stage chain per bit; the first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_comb begin
                state_next.stage1[gi] = async_in[gi];
                state_next.stage2[gi] = state_reg.stage1[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stage2;

endmodule

// *** hdl/lspm_regs.sv ***
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps

// How it works
// - Bit 0 of link_status_second reads the de-emphasis level now in use at 5 Gbps, 0 for -6.0 dB, 1 for -3.5 dB.
// - At 2.5 GT/s that bit just shows whatever the PHY drives and carries no meaning.
// - The second slot capability, control and status registers are reserved and always read zero.
// - Bits 7:0 of the power management header read the fixed identifier 1.
// - Bits 15:8 of the header hold a loadable pointer to the next capability.
// - Bits 18:16 of the header are read-only and read 3.
// - Bit 21 is a loadable device-specific-init flag that resets to 0.
// - Bits 24:22 read zero since no auxiliary current is drawn.
// - Bits 25 and 26 read zero since neither intermediate low-power state is supported.
// - Bits 31:27 are a loadable mask of the states in which a PME may be generated.
// - That mask resets with only bits 27, 30 and 31 set.
// - PME messages are never forwarded while the port is in cold D3.
// - Writing the mask changes only its read-back value, never the states that really forward PME.
module lspm_regs (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [lspm_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic phy_current_deemph_level,
    input wire logic phy_rate_5g,
    input wire logic pm_aux_cold,
    input wire logic [1:0] pm_state,
    input wire logic pme_msg_in,
    output logic pme_msg_fwd
);

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic load_en;
        logic [7:0] next_capability_pointer;
        logic device_specific_init_flag;
        logic [4:0] pme_support_mask;
        logic pme_fwd;
    } lspm_state_s;

    lspm_state_s state_reg;
    lspm_state_s state_next;

    logic [2:0] phy_sync;
    logic req;
    logic wr_commit;
    logic [9:0] idx;
    logic adr_aligned;
    logic [31:0] pm_cap_word;
    logic [31:0] rd_word;
    logic [4:0] pme_behave_mask;
    logic [2:0] state_pos;
    logic cold_now;

    // PHY status and the cold indication come from outside this clock
    lspm_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in({pm_aux_cold, phy_rate_5g, phy_current_deemph_level}),
        .sync_out(phy_sync)
    );

    assign cold_now = phy_sync[2];
    assign req = wb_cyc_i && wb_stb_i;
    // The write lands at the edge where the master sees ack high
    assign wr_commit = req && wb_we_i && state_reg.ack;
    assign idx = wb_adr_i[lspm_pkg::ADR_W-1:2];
    assign adr_aligned = (wb_adr_i[1:0] == 2'h0);

    // Only the tie-offs are constants; loadable fields come from flops
    always_comb begin
        pm_cap_word = '0;
        pm_cap_word[lspm_pkg::CAP_IDENT_LSB +: 8] = lspm_pkg::CAPABILITY_IDENTIFIER;
        pm_cap_word[lspm_pkg::NEXT_PTR_LSB +: 8] = state_reg.next_capability_pointer;
        pm_cap_word[lspm_pkg::PM_REV_LSB +: 3] = lspm_pkg::PM_SPEC_REVISION_VALUE;
        pm_cap_word[lspm_pkg::INIT_FLAG_BIT] = state_reg.device_specific_init_flag;
        pm_cap_word[lspm_pkg::AUX_CURRENT_LSB +: 3] = lspm_pkg::AUX_CURRENT_VALUE;
        pm_cap_word[lspm_pkg::LPS1_BIT] = 1'b0;
        pm_cap_word[lspm_pkg::LPS2_BIT] = 1'b0;
        pm_cap_word[lspm_pkg::PMES_LSB +: 5] = state_reg.pme_support_mask;
    end

    // Read mux; unmapped and reserved locations return zero
    always_comb begin
        rd_word = '0;
        if (adr_aligned) begin
            case (idx)
                lspm_pkg::LINK_STATUS_SECOND_IDX: begin
                    // Undefined at 2.5 GT/s; the PHY value is shown as is
                    rd_word[0] = phy_sync[0];
                end
                lspm_pkg::SLOT_CAPABILITIES_SECOND_IDX: begin
                    rd_word = '0;
                end
                lspm_pkg::SLOT_CONTROL_SECOND_IDX: begin
                    rd_word = '0;
                end
                lspm_pkg::SLOT_STATUS_SECOND_IDX: begin
                    rd_word = '0;
                end
                lspm_pkg::POWER_MGMT_CAPABILITIES_IDX: begin
                    rd_word = pm_cap_word;
                end
                lspm_pkg::LOAD_CONTROL_IDX: begin
                    rd_word[lspm_pkg::LOAD_EN_BIT] = state_reg.load_en;
                end
                lspm_pkg::LINK_MONITOR_IDX: begin
                    rd_word[lspm_pkg::MON_RATE_BIT] = phy_sync[1];
                    rd_word[lspm_pkg::MON_DEEMPH_BIT] = phy_sync[0];
                    rd_word[lspm_pkg::MON_COLD_BIT] = cold_now;
                end
                default: begin
                    rd_word = '0;
                end
            endcase
        end
    end

    // PME forwarding follows the reset mask with its D3cold bit cleared, never the loaded one
    always_comb begin
        pme_behave_mask = lspm_pkg::PME_SUPPORT_RST;
        pme_behave_mask[lspm_pkg::PME_D3COLD_POS] = 1'b0;
        if (cold_now) begin
            state_pos = 3'(lspm_pkg::PME_D3COLD_POS);
        end else begin
            state_pos = 3'(lspm_pkg::PME_D0_POS) + {1'b0, pm_state};
        end
    end

    always_comb begin
        state_next = state_reg;
        // Ack for one cycle, then drop it so a held strobe is not answered on two cycles in a row
        state_next.ack = req && !state_reg.ack;
        if (req && !state_reg.ack) begin
            state_next.dat = wb_we_i ? lspm_pkg::DATA_RST : rd_word;
        end
        state_next.pme_fwd = pme_msg_in && pme_behave_mask[state_pos];
        if (wr_commit && adr_aligned) begin
            case (idx)
                lspm_pkg::LOAD_CONTROL_IDX: begin
                    if (wb_sel_i[0]) begin
                        state_next.load_en = wb_dat_i[lspm_pkg::LOAD_EN_BIT];
                    end
                end
                lspm_pkg::POWER_MGMT_CAPABILITIES_IDX: begin
                    // Fixed fields have no storage, so writes to them vanish
                    if (state_reg.load_en) begin
                        if (wb_sel_i[1]) begin
                            state_next.next_capability_pointer = wb_dat_i[lspm_pkg::NEXT_PTR_LSB +: 8];
                        end
                        if (wb_sel_i[2]) begin
                            state_next.device_specific_init_flag = wb_dat_i[lspm_pkg::INIT_FLAG_BIT];
                        end
                        if (wb_sel_i[3]) begin
                            state_next.pme_support_mask = wb_dat_i[lspm_pkg::PMES_LSB +: 5];
                        end
                    end
                end
                default: begin
                    state_next.load_en = state_reg.load_en;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg.ack <= 1'b0;
            state_reg.dat <= lspm_pkg::DATA_RST;
            state_reg.load_en <= 1'b0;
            state_reg.next_capability_pointer <= lspm_pkg::NEXT_PTR_RST;
            state_reg.device_specific_init_flag <= lspm_pkg::INIT_FLAG_RST;
            state_reg.pme_support_mask <= lspm_pkg::PME_SUPPORT_RST;
            state_reg.pme_fwd <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.dat;
    assign pme_msg_fwd = state_reg.pme_fwd;

endmodule

// *** test/lspm_regs_asserts.sv ***
`timescale 1ns/1ps
module lspm_regs_chk (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [lspm_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic pm_aux_cold,
    input wire logic [1:0] pm_state,
    input wire logic pme_msg_in,
    input wire logic pme_msg_fwd
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire logic rd_ack = wb_ack_o && !wb_we_i;
    // Four cycles covers the two-flop sync of the cold level
    sequence warm_s; !pm_aux_cold [*4]; endsequence
    sequence cold_s; pm_aux_cold [*4]; endsequence
    sequence fwd_ok_s; pme_msg_in && (pm_state == 2'h0 || pm_state == lspm_pkg::PSTATE_D3HOT); endsequence
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_rsvd_zero: assert property (rd_ack && wb_adr_i inside {12'h1D0, 12'h1E0, 12'h1E8} |-> wb_dat_o == 32'h0)
        else $error("reserved reads nonzero");
    chk_link_upper: assert property (rd_ack && wb_adr_i == 12'h1C8 |-> wb_dat_o[31:1] == 31'h0)
        else $error("link status upper bits set");
    chk_pm_fixed: assert property (rd_ack && wb_adr_i == 12'h300 |-> wb_dat_o[7:0] == 8'h01
        && wb_dat_o[20:16] == 5'h03 && wb_dat_o[26:22] == 5'h00)
        else $error("pm fixed fields wrong");
    chk_fwd_cause: assert property (pme_msg_fwd |-> $past(pme_msg_in) && $past(pm_state) inside {2'h0, 2'h3})
        else $error("pme forwarded without cause");
    chk_fwd_warm: assert property (warm_s ##0 fwd_ok_s |=> pme_msg_fwd)
        else $error("pme not forwarded");
    chk_fwd_cold: assert property (cold_s ##0 pme_msg_in |=> !pme_msg_fwd)
        else $error("pme forwarded in cold state");
endmodule
bind lspm_regs lspm_regs_chk chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pm_aux_cold(pm_aux_cold),
    .pm_state(pm_state), .pme_msg_in(pme_msg_in), .pme_msg_fwd(pme_msg_fwd));

// *** test/test_link_status_pm_capability_regs.sv ***
`timescale 1ns/1ps
module test_link_status_pm_capability_regs;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0, we = 1'b0, ack, deemph = 1'b0, rate = 1'b0, cold = 1'b0, pme_in = 1'b0, fwd;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0, rdat, rd, val, seed = 32'hF980;
    logic [3:0] sel = 4'hF, lanes = 4'hF;
    logic [1:0] pstate = 2'h0;
    logic [11:0] bad [5] = '{12'h1D0, 12'h1E0, 12'h1E8, 12'h1D2, 12'h004};
    int err_total = 0;
    int samples_checked = 0;
    always #10 clk_sys = ~clk_sys;
    lspm_regs dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .phy_current_deemph_level(deemph), .phy_rate_5g(rate), .pm_aux_cold(cold), .pm_state(pstate),
        .pme_msg_in(pme_in), .pme_msg_fwd(fwd));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Only next pointer, init flag and PME mask follow the data
    function automatic logic [31:0] pm_word(input logic [31:0] ld);
        return (ld & 32'hF820FF00) | 32'h00030001;
    endfunction
    task automatic wrap_up;
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= lanes;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            err_total++;
            wrap_up();
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wb(1'b0, 12'h300, 32'h0);
        check("pm reset", rd, pm_word(32'hC8000000));
        foreach (bad[i]) begin
            seed = xs(seed);
            wb(1'b1, bad[i], seed);
            wb(1'b0, bad[i], 32'h0);
            check("reserved", rd, 32'h0);
        end
        seed = xs(seed);
        wb(1'b1, 12'h300, seed);
        wb(1'b0, 12'h300, 32'h0);
        check("pm locked", rd, pm_word(32'hC8000000));
        wb(1'b1, 12'h3C0, 32'h1);
        wb(1'b0, 12'h3C0, 32'h0);
        check("load open", rd, 32'h1);
        // Last load sets every mask bit so the forwarding checks see a mask unlike the reset one
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            val = (i == 0) ? 32'h0 : (i == 3) ? 32'hFFFFFFFF : seed;
            wb(1'b1, 12'h300, val);
            wb(1'b0, 12'h300, 32'h0);
            check("pm loaded", rd, pm_word(val));
        end
        lanes = 4'h2;
        wb(1'b1, 12'h300, 32'h0);
        lanes = 4'hF;
        wb(1'b0, 12'h300, 32'h0);
        check("pm byte lane", rd, pm_word(32'hFFFF00FF));
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            {deemph, rate} <= i[1:0];
            repeat (4) @(posedge clk_sys);
            wb(1'b0, 12'h1C8, 32'h0);
            check("deemph", rd, {31'h0, i[1]});
            wb(1'b0, 12'h3C4, 32'h0);
            check("monitor", rd, {30'h0, i[1:0]});
        end
        // Mask now holds a loaded value; forwarding must ignore it
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            pstate <= i[1:0];
            cold <= i[2];
            repeat (4) @(posedge clk_sys);
            wb(1'b0, 12'h3C4, 32'h0);
            check("monitor cold", rd, {29'h0, i[2], 2'h3});
            pme_in <= 1'b1;
            @(posedge clk_sys);
            pme_in <= 1'b0;
            @(posedge clk_sys);
            check("pme fwd", {31'h0, fwd}, {31'h0, !i[2] && (i[1:0] == 2'h0 || i[1:0] == 2'h3)});
        end
        // A second reset must bring the loaded fields and the load gate back to their defaults
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wb(1'b0, 12'h300, 32'h0);
        check("pm after reset", rd, pm_word(32'hC8000000));
        wb(1'b0, 12'h3C0, 32'h0);
        check("load after reset", rd, 32'h0);
        wrap_up();
    end
endmodule
